// ---- src/input_select_pkg.sv ----
// input source selection: constants, register map and carrier types
// assumes one clock domain; receivers report lock and rate as raw pins
package input_select_pkg;

  localparam int NCH    = 4;
  localparam int SW     = 24;
  localparam int RATE_W = 8;
  localparam int GAIN_W = 9;
  localparam int TRIM_W = 8;
  localparam int OUTG_W = 10;

  // gain codes count 0.2 dB steps around 0 dB
  localparam logic signed [GAIN_W-1:0] GAIN_MIN = -9'sd200;
  localparam logic signed [GAIN_W-1:0] GAIN_MAX = 9'sd100;

  localparam logic [RATE_W-1:0] RATE_MIN_KHZ = 8'd28;
  localparam logic [RATE_W-1:0] RATE_MAX_KHZ = 8'd108;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_GAIN     = 8'h10;
  localparam logic [7:0] ADDR_TRIM_AES = 8'h20;
  localparam logic [7:0] ADDR_TRIM_NET = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h28;

  // control field positions
  localparam int CTRL_POLICY_LSB = 0;
  localparam int CTRL_MANUAL_LSB = 4;
  localparam int CTRL_INVERT_BIT = 8;
  localparam int CTRL_MUTE_BIT   = 9;

  // status field positions
  localparam int STAT_SEL_LSB   = 0;
  localparam int STAT_AES_LSB   = 8;
  localparam int STAT_NET_BIT   = 12;
  localparam int STAT_FIT_BIT   = 13;

  typedef enum logic [2:0] {
    POL_MANUAL  = 3'b000,
    POL_AES_ANA = 3'b001,
    POL_NET_ANA = 3'b010,
    POL_NET_AES = 3'b011,
    POL_AUTO    = 3'b100
  } policy_e;

  typedef enum logic [1:0] {
    SRC_ANA = 2'b00,
    SRC_AES = 2'b01,
    SRC_NET = 2'b10
  } source_e;

  typedef struct packed {
    policy_e policy;
    source_e manual;
    logic    invert;
    logic    mute;
  } ctrl_s;

  typedef struct packed {
    logic signed [SW-1:0] ana;
    logic signed [SW-1:0] aes;
    logic signed [SW-1:0] net;
  } src_frame_s;

  typedef struct packed {
    logic signed [NCH-1:0][SW-1:0]     sample;
    logic signed [NCH-1:0][OUTG_W-1:0] gain;
    source_e     [NCH-1:0]             source;
    logic        [NCH-1:0][RATE_W-1:0] rate_khz;
  } out_word_s;

  typedef struct packed {
    ctrl_s      [NCH-1:0]             ctrl;
    logic       [NCH-1:0][GAIN_W-1:0] gain;
    logic       [TRIM_W-1:0]          trim_aes;
    logic       [TRIM_W-1:0]          trim_net;
    logic       [NCH-1:0]             aes_lock_m;
    logic       [NCH-1:0]             aes_lock;
    logic       [NCH-1:0][RATE_W-1:0] aes_rate_m;
    logic       [NCH-1:0][RATE_W-1:0] aes_rate;
    logic                             net_lock_m;
    logic                             net_lock;
    logic       [RATE_W-1:0]          net_rate_m;
    logic       [RATE_W-1:0]          net_rate;
    logic                             fit_m;
    logic                             fit;
    source_e    [NCH-1:0]             sel;
    logic                             aes_led;
    logic                             net_led;
    logic       [1:0]                 count;
    logic                             out_valid;
    logic                             in_ready;
    out_word_s                        head;
    out_word_s                        tail;
    logic       [31:0]                rdata;
  } state_s;

  // manual policy, analogue source, 0 dB, zero trims, empty buffer
  localparam state_s STATE_RESET = '0;

endpackage : input_select_pkg

// ---- src/input_source_failover_select.sv ----
// per-channel input source selection, polarity and mute; AES and network trims shared by all channels, none for analogue
// assumes lock/rate pins come from receivers on other clocks, audio
// frames and register bus on i_clock; the dsp applies o_out.gain
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
module input_source_failover_select #(
  parameter logic [input_select_pkg::NCH-1:0] AES_CAPABLE = 4'hf
) (
  input  wire logic                                                i_clock,
  input  wire logic                                                i_resetn,
  input  wire logic [7:0]                                          i_reg_addr,
  input  wire logic [31:0]                                         i_reg_wdata,
  input  wire logic                                                i_reg_write,
  input  wire logic                                                i_reg_read,
  output logic      [31:0]                                         o_reg_rdata,
  input  wire logic [input_select_pkg::NCH-1:0]                    i_aes_lock,
  input  wire logic [input_select_pkg::NCH-1:0][7:0]               i_aes_rate_khz,
  input  wire logic                                                i_net_fitted,
  input  wire logic                                                i_net_lock,
  input  wire logic [7:0]                                          i_net_rate_khz,
  input  wire logic                                                i_in_valid,
  input  wire input_select_pkg::src_frame_s [input_select_pkg::NCH-1:0] i_in_frame,
  output logic                                                     o_in_ready,
  output logic                                                     o_out_valid,
  output input_select_pkg::out_word_s                              o_out,
  input  wire logic                                                i_out_ready,
  output logic                                                     o_aes_indicator,
  output logic                                                     o_net_indicator
);
  import input_select_pkg::*;

  // ---------------------------------------------------------------
  // source choice
  // ---------------------------------------------------------------
  function automatic source_e pick(input policy_e p, input source_e m,
                                   input logic aes_ok, input logic net_ok,
                                   input logic aes_cap, input logic fit);
    source_e mp;
    // a manual choice without a live stream drops to analogue
    mp = (m == SRC_AES && aes_ok && aes_cap) ? SRC_AES :
         (m == SRC_NET && net_ok)            ? SRC_NET : SRC_ANA;
    pick = mp;
    unique case (p)
      POL_AES_ANA: if (aes_cap) begin
        pick = aes_ok ? SRC_AES : SRC_ANA;
      end
      POL_NET_ANA: if (fit) begin
        pick = net_ok ? SRC_NET : SRC_ANA;
      end
      POL_NET_AES: if (aes_cap && fit) begin
        pick = net_ok ? SRC_NET : (aes_ok ? SRC_AES : SRC_ANA);
      end
      POL_AUTO: begin
        pick = net_ok ? SRC_NET : ((aes_ok && aes_cap) ? SRC_AES : SRC_ANA);
      end
      // unsupported policy codes behave as manual
      default: pick = mp;
    endcase
  endfunction : pick

  function automatic logic rate_ok(input logic [RATE_W-1:0] r);
    rate_ok = (r >= RATE_MIN_KHZ) && (r <= RATE_MAX_KHZ);
  endfunction : rate_ok

  // invert saturates so full-scale negative does not wrap
  function automatic logic signed [SW-1:0] shape(input logic signed [SW-1:0] x,
                                                 input logic inv, input logic mute);
    shape = x;
    if (inv) begin
      shape = (x == {1'b1, {(SW-1){1'b0}}}) ? {1'b0, {(SW-1){1'b1}}} : -x;
    end
    if (mute) begin
      shape = '0;
    end
  endfunction : shape

  state_s               s;
  state_s               next_s;
  logic [NCH-1:0]       aes_ok;
  logic                 net_ok;
  logic                 push;
  logic                 pop;
  out_word_s            word;
  logic signed [GAIN_W-1:0] wgain;

  // ---------------------------------------------------------------
  // stream validity
  // ---------------------------------------------------------------
  // rate words are quasi-static and only trusted while lock holds
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      aes_ok[c] = s.aes_lock[c] && rate_ok(s.aes_rate[c]);
    end
    net_ok = s.fit && s.net_lock && rate_ok(s.net_rate);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    word   = '0;
    wgain  = '0;

    // two-stage synchronisers
    next_s.aes_lock_m = i_aes_lock;
    next_s.aes_lock   = s.aes_lock_m;
    next_s.aes_rate_m = i_aes_rate_khz;
    next_s.aes_rate   = s.aes_rate_m;
    next_s.net_lock_m = i_net_lock;
    next_s.net_lock   = s.net_lock_m;
    next_s.net_rate_m = i_net_rate_khz;
    next_s.net_rate   = s.net_rate_m;
    next_s.fit_m      = i_net_fitted;
    next_s.fit        = s.fit_m;

    // selection follows stream state every cycle
    next_s.aes_led = 1'b0;
    next_s.net_led = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      next_s.sel[c] = pick(s.ctrl[c].policy, s.ctrl[c].manual, aes_ok[c],
                           net_ok, AES_CAPABLE[c], s.fit);
      if (s.sel[c] == SRC_AES) begin
        next_s.aes_led = 1'b1;
      end
      // routed means configured for net, whether or not a cable is in
      if (s.fit && (s.ctrl[c].manual == SRC_NET ||
                    s.ctrl[c].policy == POL_NET_ANA ||
                    s.ctrl[c].policy == POL_NET_AES ||
                    s.ctrl[c].policy == POL_AUTO)) begin
        next_s.net_led = 1'b1;
      end
    end

    // output word from the frame on offer
    for (int c = 0; c < NCH; c++) begin
      unique case (s.sel[c])
        SRC_AES: begin
          word.sample[c]   = shape(i_in_frame[c].aes, s.ctrl[c].invert,
                                   s.ctrl[c].mute);
          word.gain[c]     = OUTG_W'($signed(s.gain[c])) +
                             OUTG_W'($signed(s.trim_aes));
          word.rate_khz[c] = s.aes_rate[c];
        end
        SRC_NET: begin
          word.sample[c]   = shape(i_in_frame[c].net, s.ctrl[c].invert,
                                   s.ctrl[c].mute);
          word.gain[c]     = OUTG_W'($signed(s.gain[c])) +
                             OUTG_W'($signed(s.trim_net));
          word.rate_khz[c] = s.net_rate;
        end
        default: begin
          // analogue runs on the converter clock, reported as rate 0
          word.sample[c]   = shape(i_in_frame[c].ana, s.ctrl[c].invert,
                                   s.ctrl[c].mute);
          word.gain[c]     = OUTG_W'($signed(s.gain[c]));
          word.rate_khz[c] = '0;
        end
      endcase
      word.source[c] = s.sel[c];
    end

    // two-entry buffer; head always feeds the output port
    push = i_in_valid && s.in_ready;
    pop  = s.out_valid && i_out_ready;
    if (pop) begin
      next_s.head = (s.count == 2'd2) ? s.tail : word;
    end
    if (push) begin
      if (s.count == 2'd0 || (s.count == 2'd1 && pop)) begin
        next_s.head = word;
      end else begin
        next_s.tail = word;
      end
    end
    unique case ({push, pop})
      2'b10:   next_s.count = s.count + 2'd1;
      2'b01:   next_s.count = s.count - 2'd1;
      default: next_s.count = s.count;
    endcase
    next_s.out_valid = (next_s.count != 2'd0);
    next_s.in_ready  = (next_s.count != 2'd2);

    // register writes
    if (i_reg_write) begin
      for (int c = 0; c < NCH; c++) begin
        if (i_reg_addr == ADDR_CTRL + 8'(4 * c)) begin
          next_s.ctrl[c].policy = policy_e'(i_reg_wdata[CTRL_POLICY_LSB +: 3]);
          next_s.ctrl[c].manual = source_e'(i_reg_wdata[CTRL_MANUAL_LSB +: 2]);
          next_s.ctrl[c].invert = i_reg_wdata[CTRL_INVERT_BIT];
          next_s.ctrl[c].mute   = i_reg_wdata[CTRL_MUTE_BIT];
        end
        if (i_reg_addr == ADDR_GAIN + 8'(4 * c)) begin
          wgain = $signed(i_reg_wdata[GAIN_W-1:0]);
          // out-of-range codes clamp to the nearest end
          if ($signed(i_reg_wdata) < $signed(32'(GAIN_MIN))) begin
            wgain = GAIN_MIN;
          end else if ($signed(i_reg_wdata) > $signed(32'(GAIN_MAX))) begin
            wgain = GAIN_MAX;
          end
          next_s.gain[c] = wgain;
        end
      end
      if (i_reg_addr == ADDR_TRIM_AES) begin
        next_s.trim_aes = i_reg_wdata[TRIM_W-1:0];
      end
      if (i_reg_addr == ADDR_TRIM_NET) begin
        next_s.trim_net = i_reg_wdata[TRIM_W-1:0];
      end
    end

    // register reads, data valid the cycle after the strobe
    next_s.rdata = '0;
    if (i_reg_read) begin
      for (int c = 0; c < NCH; c++) begin
        if (i_reg_addr == ADDR_CTRL + 8'(4 * c)) begin
          next_s.rdata[CTRL_POLICY_LSB +: 3] = s.ctrl[c].policy;
          next_s.rdata[CTRL_MANUAL_LSB +: 2] = s.ctrl[c].manual;
          next_s.rdata[CTRL_INVERT_BIT]      = s.ctrl[c].invert;
          next_s.rdata[CTRL_MUTE_BIT]        = s.ctrl[c].mute;
        end
        if (i_reg_addr == ADDR_GAIN + 8'(4 * c)) begin
          next_s.rdata = 32'($signed(s.gain[c]));
        end
      end
      if (i_reg_addr == ADDR_TRIM_AES) begin
        next_s.rdata = 32'($signed(s.trim_aes));
      end
      if (i_reg_addr == ADDR_TRIM_NET) begin
        next_s.rdata = 32'($signed(s.trim_net));
      end
      if (i_reg_addr == ADDR_STATUS) begin
        for (int c = 0; c < NCH; c++) begin
          next_s.rdata[STAT_SEL_LSB + 2 * c +: 2] = s.sel[c];
        end
        next_s.rdata[STAT_AES_LSB +: NCH] = aes_ok;
        next_s.rdata[STAT_NET_BIT]        = net_ok;
        next_s.rdata[STAT_FIT_BIT]        = s.fit;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  always_comb begin
    o_reg_rdata     = s.rdata;
    o_in_ready      = s.in_ready;
    o_out_valid     = s.out_valid;
    o_out           = s.head;
    o_aes_indicator = s.aes_led;
    o_net_indicator = s.net_led;
  end

endmodule : input_source_failover_select

// ---- verif/input_source_failover_select_chk.sv ----
// port-level properties of the input source selection block
// assumes it is bound to input_source_failover_select, one clock domain
`timescale 1ns/100ps
module input_source_failover_select_chk (
  input wire logic                             i_clock,
  input wire logic                             i_resetn,
  input wire logic [7:0]                       i_reg_addr,
  input wire logic [31:0]                      i_reg_wdata,
  input wire logic                             i_reg_write,
  input wire logic                             i_reg_read,
  input wire logic [31:0]                      o_reg_rdata,
  input wire logic [input_select_pkg::NCH-1:0] i_aes_lock,
  input wire logic [input_select_pkg::NCH-1:0][7:0] i_aes_rate_khz,
  input wire logic                             i_net_fitted,
  input wire logic                             i_in_valid,
  input wire logic                             o_in_ready,
  input wire logic                             o_out_valid,
  input wire input_select_pkg::out_word_s      o_out,
  input wire logic                             i_out_ready,
  input wire logic                             o_aes_indicator,
  input wire logic                             o_net_indicator
);
  import input_select_pkg::*;
  logic mute0;
  // ----------------------------------------------------------------
  // shadow of channel 0 mute, so silence is tied to its cause
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mute0 <= 1'b0;
    end else if (i_reg_write && i_reg_addr == ADDR_CTRL) begin
      mute0 <= i_reg_wdata[CTRL_MUTE_BIT];
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!$past(i_reg_read) |-> o_reg_rdata == '0)
    else $error("read data outside its slot");
  a_hold_stall: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("output word changed while stalled");
  a_push_valid: assert property (i_in_valid && o_in_ready |=> o_out_valid)
    else $error("accepted frame not offered");
  // a stall longer than two pushes must refuse further frames
  a_full_refuse: assert property ((i_in_valid && !i_out_ready)[*4] |=> !o_in_ready)
    else $error("buffer took a third word");
  a_aes_dead: assert property ((!i_aes_lock[0] && i_in_valid && o_in_ready)[*8]
    |=> o_out.source[0] != SRC_AES) else $error("unlocked digital stream used");
  a_aes_rate: assert property ((i_aes_rate_khz[1] > RATE_MAX_KHZ && i_in_valid
    && o_in_ready)[*8] |=> o_out.source[1] != SRC_AES) else $error("bad rate used");
  a_mute_zero: assert property ((mute0 && i_in_valid && o_in_ready)[*4]
    |=> o_out.sample[0] == '0) else $error("muted channel not silent");
  a_aes_led_off: assert property ((i_aes_lock == '0)[*8] |=> !o_aes_indicator)
    else $error("digital indicator lit with no stream");
  a_net_led_off: assert property ((!i_net_fitted)[*6] |=> !o_net_indicator)
    else $error("network indicator lit without card");
  a_rate_ana: assert property (o_out_valid && o_out.source[0] == SRC_ANA
    |-> o_out.rate_khz[0] == '0) else $error("analogue word carries a rate");
  c_stall: cover property (o_out_valid && !i_out_ready);
  c_aes_led: cover property (o_aes_indicator);
  c_net_src: cover property (o_out_valid && o_out.source[0] == SRC_NET);
endmodule : input_source_failover_select_chk

bind input_source_failover_select input_source_failover_select_chk u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .o_reg_rdata(o_reg_rdata), .i_aes_lock(i_aes_lock), .i_aes_rate_khz(i_aes_rate_khz),
  .i_net_fitted(i_net_fitted), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
  .o_out_valid(o_out_valid), .o_out(o_out), .i_out_ready(i_out_ready),
  .o_aes_indicator(o_aes_indicator), .o_net_indicator(o_net_indicator)
);

// ---- verif/audio_source_model.sv ----
// stand-in for the audio receivers feeding one frame per transfer
// assumes the block's valid/ready stream on the same clock
`timescale 1ns/100ps
module audio_source_model (
  input  wire logic                           i_clock,
  input  wire logic                           i_resetn,
  input  wire logic                           i_ready,
  output logic                                o_valid,
  output input_select_pkg::src_frame_s [input_select_pkg::NCH-1:0] o_frame
);
  import input_select_pkg::*;
  logic [15:0] seq;
  // sample is {source tag, channel, sequence} so a word names its origin
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      o_frame[c].ana = {4'h1, 4'(c), seq};
      o_frame[c].aes = {4'h2, 4'(c), seq};
      o_frame[c].net = {4'h3, 4'(c), seq};
    end
  end
  // frame held until taken, since the block may refuse it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      seq     <= 16'h0001;
    end else begin
      o_valid <= 1'b1;
      if (o_valid && i_ready) begin
        seq <= seq + 16'h0001;
      end
    end
  end
endmodule : audio_source_model

// ---- verif/input_source_failover_select_tb.sv ----
// self-checking bench for the input source selection block
// assumes the audio source model and the bound checker beside it
`timescale 1ns/100ps
module input_source_failover_select_tb;
  import input_select_pkg::*;
  logic                  clock, resetn, wr_s, rd_s, fitted, net_lock;
  logic                  in_valid, in_ready, out_valid, out_ready, aes_ind, net_ind;
  logic [7:0]            addr, net_rate;
  logic [31:0]           wdata, rdata;
  logic [NCH-1:0]        aes_lock;
  logic [NCH-1:0][7:0]   aes_rate;
  src_frame_s [NCH-1:0]  frame;
  out_word_s             out_word;
  int                    errors, compares;

  always #2 clock = ~clock;

  input_source_failover_select u_input_source_failover_select (
    .i_clock(clock), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr_s), .i_reg_read(rd_s), .o_reg_rdata(rdata),
    .i_aes_lock(aes_lock), .i_aes_rate_khz(aes_rate), .i_net_fitted(fitted),
    .i_net_lock(net_lock), .i_net_rate_khz(net_rate), .i_in_valid(in_valid),
    .i_in_frame(frame), .o_in_ready(in_ready), .o_out_valid(out_valid),
    .o_out(out_word), .i_out_ready(out_ready), .o_aes_indicator(aes_ind),
    .o_net_indicator(net_ind)
  );
  audio_source_model u_audio_source_model (
    .i_clock(clock), .i_resetn(resetn), .i_ready(in_ready),
    .o_valid(in_valid), .o_frame(frame)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    @(negedge clock);
    cmp(rdata, e);
  endtask : rdc

  // bounded wait for an offered word; words drain while ready is high
  task automatic wt;
    int k;
    k = 0;
    @(negedge clock);
    while (out_valid !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    if (out_valid !== 1'b1) begin
      errors++;
      test_done();
    end
  endtask : wt

  // set policy and receiver state, let sync and selection settle, check origin
  task automatic pol(input int c, input logic [31:0] v, input logic [3:0] al,
                     input logic [7:0] ar, input logic nl, input logic f,
                     input source_e e);
    wr(ADDR_CTRL + 8'(4 * c), v);
    aes_lock <= al;
    aes_rate <= {NCH{ar}};
    net_lock <= nl;
    fitted   <= f;
    repeat (12) @(posedge clock);
    wt();
    cmp(32'(out_word.source[c]), 32'(e));
    cmp(32'(out_word.sample[c][23:20]), 32'(e) + 32'h1);
  endtask : pol
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] s;
    clock = 0;
    resetn = 0;
    wr_s = 0;
    rd_s = 0;
    addr = 0;
    wdata = 0;
    aes_lock = 0;
    aes_rate = {NCH{8'h30}};
    fitted = 0;
    net_lock = 0;
    net_rate = 8'h60;
    out_ready = 1;
    errors = 0;
    compares = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_GAIN, 32'h0);
    rdc(ADDR_TRIM_AES, 32'h0);
    rdc(ADDR_STATUS, 32'h0);
    wr(ADDR_GAIN, 32'hfffffc18);
    rdc(ADDR_GAIN, 32'hffffff38);
    wr(ADDR_GAIN, 32'h3e8);
    rdc(ADDR_GAIN, 32'h64);
    wr(ADDR_GAIN, 32'h5);
    wr(ADDR_TRIM_AES, 32'ha);
    wr(ADDR_TRIM_NET, 32'h14);
    rdc(ADDR_TRIM_NET, 32'h14);
    rdc(8'hfc, 32'h0);
    pol(0, 32'h10, 4'hf, 8'h30, 1, 1, SRC_AES);
    cmp(32'(out_word.gain[0]), 32'hf);
    cmp(32'(aes_ind), 32'h1);
    pol(0, 32'h10, 4'h0, 8'h30, 1, 1, SRC_ANA);
    cmp(32'(out_word.gain[0]), 32'h5);
    cmp(32'(aes_ind), 32'h0);
    pol(0, 32'h20, 4'hf, 8'h30, 1, 1, SRC_NET);
    cmp(32'(out_word.gain[0]), 32'h19);
    cmp(32'(out_word.rate_khz[0]), 32'h60);
    pol(0, 32'h20, 4'hf, 8'h30, 0, 1, SRC_ANA);
    pol(1, 32'h1, 4'hf, 8'h30, 1, 1, SRC_AES);
    pol(1, 32'h1, 4'hd, 8'h30, 1, 1, SRC_ANA);
    pol(1, 32'h1, 4'hf, 8'h78, 1, 1, SRC_ANA);
    pol(1, 32'h1, 4'hf, 8'h1c, 1, 1, SRC_AES);
    cmp(32'(out_word.rate_khz[1]), 32'h1c);
    pol(1, 32'h1, 4'hf, 8'h6c, 1, 1, SRC_AES);
    pol(1, 32'h1, 4'hf, 8'h1b, 1, 1, SRC_ANA);
    pol(2, 32'h2, 4'hf, 8'h30, 1, 1, SRC_NET);
    cmp(32'(net_ind), 32'h1);
    pol(2, 32'h2, 4'hf, 8'h30, 0, 1, SRC_ANA);
    cmp(32'(net_ind), 32'h1);
    pol(3, 32'h3, 4'hf, 8'h30, 1, 1, SRC_NET);
    pol(3, 32'h3, 4'hf, 8'h30, 0, 1, SRC_AES);
    pol(3, 32'h3, 4'hf, 8'h30, 1, 0, SRC_ANA);
    cmp(32'(net_ind), 32'h0);
    pol(0, 32'h4, 4'hf, 8'h30, 1, 1, SRC_NET);
    pol(0, 32'h4, 4'hf, 8'h30, 0, 1, SRC_AES);
    pol(0, 32'h4, 4'h0, 8'h30, 0, 1, SRC_ANA);
    wr(ADDR_CTRL, 32'h100);
    repeat (12) @(posedge clock);
    wt();
    cmp(32'(out_word.sample[0][23]), 32'h1);
    wr(ADDR_CTRL, 32'h200);
    repeat (12) @(posedge clock);
    wt();
    cmp(32'(out_word.sample[0]), 32'h0);
    wr(ADDR_CTRL, 32'h0);
    // the word taken on the write's own edge still carries the old mute
    repeat (2) @(posedge clock);
    // stall the receiver: buffer fills, refuses, then drains in order
    out_ready <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    cmp(32'(in_ready), 32'h0);
    s = out_word.sample[0][15:0];
    @(posedge clock);
    out_ready <= 1'b1;
    @(negedge clock);
    @(negedge clock);
    cmp(32'(out_word.sample[0][15:0]), 32'(s) + 32'h1);
    test_done();
  end
endmodule : input_source_failover_select_tb
